// ===== core/fpa_pkg.sv
// Constants shared by the fieldbus parameter access block
package fpa_pkg;
  localparam logic [15:0] SAVE_CODE        = 16'h03e8;
  localparam logic [15:0] SAVE_CODE_BACKUP = 16'h03e9;
  localparam logic [7:0]  PARAM_IDX_HI     = 8'h20;
  localparam logic [7:0]  CFG_MENU         = 8'h11;
  localparam logic [7:0]  ALIAS_MENU       = 8'h3d;
  localparam logic [7:0]  ALIAS_PARAM      = 8'h01;
  localparam logic [7:0]  APP_MENU         = 8'h14;
  localparam logic [7:0]  P_SAVE           = 8'h00;
  localparam logic [7:0]  P_ALIAS          = 8'h03;
  localparam logic [7:0]  P_STATE          = 8'h04;
  localparam logic [7:0]  P_RESTART        = 8'h20;
  localparam logic [15:0] ALIAS_RESET      = 16'h0000;
  localparam logic [15:0] SII_ALIAS_WORD   = 16'h0004;
  localparam logic [15:0] REG_ALIAS        = 16'h0012;
  localparam logic [15:0] IDX_SM_ASSIGN    = 16'h1c12;
  localparam logic [6:0]  RX_MAP_HI        = 7'h0b;
  localparam logic [6:0]  TX_MAP_HI        = 7'h0d;
  localparam logic [15:0] AL_RESET_NEEDED  = 16'h0001;
  localparam logic [31:0] AB_NO_OBJECT     = 32'h06020000;
  localparam logic [31:0] AB_NO_SUB        = 32'h06090011;
  localparam logic [31:0] AB_BAD_CMD       = 32'h05040001;
  localparam logic [31:0] AB_READ_ONLY     = 32'h06010002;
  localparam logic [31:0] AB_RANGE         = 32'h06090030;
  localparam logic [31:0] AB_NOT_MAPPABLE  = 32'h06040041;
  localparam int          MENU_COUNT       = 64;
  localparam int          PARAM_COUNT      = 51;

  typedef enum logic [1:0] {
    SRV_NONE     = 2'b00,
    SRV_DOWNLOAD = 2'b01,
    SRV_UPLOAD   = 2'b10,
    SRV_ABORT    = 2'b11
  } fpa_srv_t;

  typedef enum logic [3:0] {
    FB_INIT   = 4'b0001,
    FB_PREOP  = 4'b0010,
    FB_SAFEOP = 4'b0100,
    FB_OP     = 4'b1000
  } fpa_fb_state_t;
endpackage : fpa_pkg

// ===== core/fpa_param_store.sv
// Drive parameter store shared by fieldbus and keypad paths
`timescale 1ns/1ns
module fpa_param_store
  import fpa_pkg::*;
#(
  parameter int MENUS  = MENU_COUNT,
  parameter int PARAMS = PARAM_COUNT
) (
  input  wire logic        sys_clk_i,  // System clock
  input  wire logic        sys_rst_i,  // Synchronous reset
  input  wire logic        a_we_i,     // Fieldbus write
  input  wire logic [7:0]  a_menu_i,   // Fieldbus menu
  input  wire logic [7:0]  a_param_i,  // Fieldbus parameter
  input  wire logic [31:0] a_wdata_i,  // Fieldbus write data
  output logic      [31:0] a_rdata_o,  // Fieldbus read data
  input  wire logic        b_we_i,     // Keypad write
  input  wire logic [7:0]  b_menu_i,   // Keypad menu
  input  wire logic [7:0]  b_param_i,  // Keypad parameter
  input  wire logic [31:0] b_wdata_i,  // Keypad write data
  output logic      [31:0] b_rdata_o   // Keypad read data
);
  typedef struct packed {
    logic [MENUS-1:0][PARAMS-1:0][31:0] mem;
  } fpa_store_t;

  fpa_store_t st_reg;
  fpa_store_t st_next;

  function automatic logic in_range(input logic [7:0] m, input logic [7:0] p);
    in_range = (32'(m) < MENUS) && (32'(p) < PARAMS);
  endfunction : in_range

  // One location per parameter, so both paths see one value
  always_comb begin
    st_next = st_reg;
    if (b_we_i && in_range(b_menu_i, b_param_i)) begin  // R23
      st_next.mem[b_menu_i][b_param_i] = b_wdata_i;
    end
    if (a_we_i && in_range(a_menu_i, a_param_i)) begin  // R23
      st_next.mem[a_menu_i][a_param_i] = a_wdata_i;
    end
  end

  always_comb begin
    a_rdata_o = in_range(a_menu_i, a_param_i) ? st_reg.mem[a_menu_i][a_param_i] : 32'h0;
    b_rdata_o = in_range(b_menu_i, b_param_i) ? st_reg.mem[b_menu_i][b_param_i] : 32'h0;
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : fpa_param_store

// ===== core/fpa_access.sv
// Fieldbus parameter access: SDO decode, config params, PDO checks
// Overview of operation
// R01: Save command 1000 followed by a reset press saves drive parameters.
// R02: On backup supply only, save command 1001 triggers the save.
// R03: Save covers all parameters except the applications menu; link unaffected.
// R04: New interface configuration takes effect only after restart.
// R05: Station alias is read/write, default 0, range 0 to 65535.
// R06: Changed alias is committed on the INIT to PRE-OP transition.
// R07: Alias change sets a status code asking for option reset.
// R08: Stored alias readable at info word 0x0004 and register 0x0012.
// R09: Run-state reports one-hot state 1, 2, 4, 8; default 1.
// R10: Run-state is overwritten with the real state; writes never persist.
// R11: Writing 1 to restart re-initialises, then clears back to 0.
// R12: Restart never writes configuration to non-volatile storage.
// R13: Second PDO in a sync manager is always low priority.
// R14: Slow parameter in first PDO of a multi-PDO manager is aborted.
// R15: Single PDO holding a slow parameter runs wholly at low priority.
// R16: Any drive parameter may be mapped into a PDO; code aborts a slow one in the first PDO of a multi-PDO manager.
// R17: Every object and drive parameter is reachable by SDO.
// R18: Parameter index is 0x2000 plus menu; sub-index is parameter.
// R19: Sub-index 0 read returns the highest parameter number.
// R20: Save command reachable by SDO only as menu 61 parameter 1.
// R21: Only download, upload and abort services are accepted.
// R22: Mapping entry: length 7:0, sub-index 15:8, index 31:16.
// R23: Fieldbus and keypad writes land in the same storage.
`timescale 1ns/1ns
module fpa_access
  import fpa_pkg::*;
#(
  parameter int          MENUS     = MENU_COUNT,
  parameter int          PARAMS    = PARAM_COUNT,
  parameter logic [7:0]  SLOW_LO   = APP_MENU,
  parameter logic [7:0]  SLOW_HI   = APP_MENU
) (
  input  wire logic        sys_clk_i,         // System clock 10 MHz
  input  wire logic        sys_rst_i,         // Synchronous reset
  input  wire logic        sdo_req_i,         // SDO request strobe
  input  wire logic [1:0]  sdo_srv_i,         // SDO service
  input  wire logic [15:0] sdo_index_i,       // Object index
  input  wire logic [7:0]  sdo_sub_i,         // Object sub-index
  input  wire logic [31:0] sdo_data_i,        // Download data
  output logic             rsp_valid_o,       // Response strobe
  output logic             rsp_abort_o,       // Response is an abort
  output logic      [31:0] rsp_data_o,        // Upload data or abort code
  input  wire logic        kpd_we_i,          // Keypad write
  input  wire logic [7:0]  kpd_menu_i,        // Keypad menu
  input  wire logic [7:0]  kpd_param_i,       // Keypad parameter
  input  wire logic [31:0] kpd_data_i,        // Keypad write data
  output logic      [31:0] kpd_rdata_o,       // Keypad read data
  input  wire logic        fsm_req_i,         // State change request
  input  wire logic [3:0]  fsm_target_i,      // Requested state
  input  wire logic        reset_btn_i,       // Reset button pin
  input  wire logic        backup_supply_i,   // Backup-only supply pin
  input  wire logic        ifc_rd_i,          // Interface read strobe
  input  wire logic        ifc_sii_i,         // 1: info word, 0: register
  input  wire logic [15:0] ifc_addr_i,        // Interface address
  output logic      [15:0] ifc_rdata_o,       // Interface read data
  output logic      [3:0]  state_ind_o,       // Run-state one-hot
  output logic      [15:0] alias_act_o,       // Alias in use
  output logic      [15:0] alias_nv_o,        // Alias in option storage
  output logic             nv_write_o,        // Alias storage write pulse
  output logic      [15:0] al_code_o,         // Status code to master
  output logic             save_pulse_o,      // Drive save pulse
  output logic      [7:0]  save_skip_menu_o,  // Menu left out of save
  output logic             restart_pulse_o,   // Interface restart pulse
  output logic      [3:0]  pdo_low_prio_o     // Per manager: first, second
);
  typedef struct packed {
    fpa_fb_state_t     fb_state;
    logic [15:0]       alias_set;
    logic [15:0]       alias_nv;
    logic [15:0]       alias_act;
    logic [15:0]       save_cmd;
    logic              restart;
    logic [15:0]       al_code;
    logic [1:0][7:0]   sm_cnt;
    logic [1:0][15:0]  sm_first;
    logic [1:0]        first_slow;
    logic [3:0]        low_prio;
    logic              rsp_valid;
    logic              rsp_abort;
    logic [31:0]       rsp_data;
    logic [31:0]       kpd_rdata;
    logic [15:0]       ifc_rdata;
    logic              save_pulse;
    logic              restart_pulse;
    logic              nv_write;
    logic [2:0]        btn_sync;
    logic [1:0]        bkp_sync;
  } fpa_state_t;

  fpa_state_t st_reg;
  fpa_state_t st_next;
  logic        btn_edge;
  logic        st_we;
  logic [31:0] st_rdata;
  logic [31:0] kp_rdata;
  logic [7:0]  menu;
  logic        is_par;
  logic        sm;

  function automatic logic is_slow(input logic [31:0] entry);
    is_slow = (entry[31:24] == PARAM_IDX_HI) && (entry[23:16] >= SLOW_LO) && (entry[23:16] <= SLOW_HI);
  endfunction : is_slow

  function automatic logic [31:0] cfg_val(input logic [7:0] p, input fpa_state_t s);
    unique case (p)
      P_SAVE:    cfg_val = {16'h0, s.save_cmd};
      P_ALIAS:   cfg_val = {16'h0, s.alias_set};
      P_STATE:   cfg_val = {28'h0, s.fb_state};
      P_RESTART: cfg_val = {31'h0, s.restart};
      default:   cfg_val = 32'h0;
    endcase
  endfunction : cfg_val

  function automatic logic is_cfg(input logic [7:0] m, input logic [7:0] p);
    is_cfg = (m == CFG_MENU) && (p == P_SAVE || p == P_ALIAS || p == P_STATE || p == P_RESTART);
  endfunction : is_cfg

  fpa_param_store #(
    .MENUS  (MENUS),
    .PARAMS (PARAMS)
  ) u_store (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .a_we_i    (st_we),
    .a_menu_i  (menu),
    .a_param_i (sdo_sub_i),
    .a_wdata_i (sdo_data_i),
    .a_rdata_o (st_rdata),
    .b_we_i    (kpd_we_i && !is_cfg(kpd_menu_i, kpd_param_i)),
    .b_menu_i  (kpd_menu_i),
    .b_param_i (kpd_param_i),
    .b_wdata_i (kpd_data_i),
    .b_rdata_o (kp_rdata)
  );

  always_comb begin
    st_next               = st_reg;
    st_we                 = 1'b0;
    menu                  = sdo_index_i[7:0];
    is_par                = (sdo_index_i[15:8] == PARAM_IDX_HI) && (32'(menu) < MENUS);  // R18
    sm                    = sdo_index_i[11];
    st_next.rsp_valid     = 1'b0;
    st_next.rsp_abort     = 1'b0;
    st_next.save_pulse    = 1'b0;
    st_next.restart_pulse = 1'b0;
    st_next.nv_write      = 1'b0;
    st_next.btn_sync      = {st_reg.btn_sync[1:0], reset_btn_i};
    st_next.bkp_sync      = {st_reg.bkp_sync[0], backup_supply_i};
    btn_edge              = st_reg.btn_sync[1] && !st_reg.btn_sync[2];
    // Keypad writes to interface settings; fieldbus below overrides
    if (kpd_we_i && kpd_menu_i == CFG_MENU) begin
      if (kpd_param_i == P_SAVE) begin
        st_next.save_cmd = kpd_data_i[15:0];
      end else if (kpd_param_i == P_ALIAS && kpd_data_i[31:16] == 16'h0) begin
        st_next.alias_set = kpd_data_i[15:0];  // R05
      end else if (kpd_param_i == P_RESTART && kpd_data_i[31:1] == 31'h0) begin
        st_next.restart = kpd_data_i[0];  // R11
      end
    end
    if (sdo_req_i) begin
      st_next.rsp_valid = 1'b1;
      st_next.rsp_data  = 32'h0;
      if (sdo_srv_i == SRV_NONE) begin
        st_next.rsp_abort = 1'b1;  // R21
        st_next.rsp_data  = AB_BAD_CMD;
      end else if (sdo_srv_i == SRV_ABORT) begin
        st_next.rsp_data = 32'h0;  // R21
      end else if (is_par && sdo_sub_i == 8'h0) begin
        st_next.rsp_abort = (sdo_srv_i == SRV_DOWNLOAD);
        st_next.rsp_data  = (sdo_srv_i == SRV_DOWNLOAD) ? AB_READ_ONLY : 32'(PARAMS - 1);  // R19
      end else if (is_par && menu == ALIAS_MENU) begin
        if (sdo_sub_i != ALIAS_PARAM) begin
          st_next.rsp_abort = 1'b1;
          st_next.rsp_data  = AB_NO_SUB;
        end else if (sdo_srv_i == SRV_DOWNLOAD) begin
          st_next.save_cmd = sdo_data_i[15:0];  // R20
        end else begin
          st_next.rsp_data = {16'h0, st_reg.save_cmd};  // R20
        end
      end else if (is_par && menu == CFG_MENU && sdo_sub_i == P_SAVE) begin
        st_next.rsp_abort = 1'b1;  // R20
        st_next.rsp_data  = AB_NO_SUB;
      end else if (is_par && is_cfg(menu, sdo_sub_i)) begin
        if (sdo_srv_i == SRV_UPLOAD) begin
          st_next.rsp_data = cfg_val(sdo_sub_i, st_reg);
        end else if (sdo_sub_i == P_ALIAS) begin
          if (sdo_data_i[31:16] != 16'h0) begin
            st_next.rsp_abort = 1'b1;  // R05
            st_next.rsp_data  = AB_RANGE;
          end else begin
            st_next.alias_set = sdo_data_i[15:0];  // R05
          end
        end else if (sdo_sub_i == P_RESTART) begin
          if (sdo_data_i[31:1] != 31'h0) begin
            st_next.rsp_abort = 1'b1;
            st_next.rsp_data  = AB_RANGE;
          end else begin
            st_next.restart = sdo_data_i[0];  // R11
          end
        end
      end else if (is_par) begin
        if (32'(sdo_sub_i) >= PARAMS) begin
          st_next.rsp_abort = 1'b1;
          st_next.rsp_data  = AB_NO_SUB;
        end else if (sdo_srv_i == SRV_DOWNLOAD) begin
          st_we = 1'b1;  // R17
        end else begin
          st_next.rsp_data = st_rdata;  // R17
        end
      end else if (sdo_index_i[15:1] == IDX_SM_ASSIGN[15:1]) begin
        if (sdo_srv_i == SRV_UPLOAD) begin
          st_next.rsp_data = (sdo_sub_i == 8'h0) ? {24'h0, st_reg.sm_cnt[sdo_index_i[0]]}
                                                 : {16'h0, st_reg.sm_first[sdo_index_i[0]]};
        end else if (sdo_sub_i == 8'h0) begin
          st_next.sm_cnt[sdo_index_i[0]] = sdo_data_i[7:0];
        end else if (sdo_sub_i == 8'h1) begin
          st_next.sm_first[sdo_index_i[0]]   = sdo_data_i[15:0];
          st_next.first_slow[sdo_index_i[0]] = 1'b0;
        end
      end else if (sdo_index_i[15:9] == RX_MAP_HI || sdo_index_i[15:9] == TX_MAP_HI) begin
        // Entries carry length, sub-index and index; any parameter is accepted except a slow one in the first PDO of a multi-PDO manager
        if (sdo_srv_i == SRV_DOWNLOAD && sdo_sub_i != 8'h0 && is_slow(sdo_data_i)  // R22
            && sdo_index_i == st_reg.sm_first[sm]) begin
          if (st_reg.sm_cnt[sm] > 8'h1) begin
            st_next.rsp_abort = 1'b1;  // R14
            st_next.rsp_data  = AB_NOT_MAPPABLE;
          end else begin
            st_next.first_slow[sm] = 1'b1;  // R16
          end
        end
      end else begin
        st_next.rsp_abort = 1'b1;
        st_next.rsp_data  = AB_NO_OBJECT;
      end
    end
    // Saving leaves the link alone; only a pulse goes to the drive
    if (btn_edge && (st_reg.save_cmd == SAVE_CODE
                     || (st_reg.bkp_sync[1] && st_reg.save_cmd == SAVE_CODE_BACKUP))) begin
      st_next.save_pulse = 1'b1;  // R01 R02 R03
      st_next.save_cmd   = 16'h0;
    end
    if (st_reg.restart) begin
      // One cycle of ON, then back to OFF; nothing goes to storage
      st_next.restart       = 1'b0;  // R11 R12
      st_next.restart_pulse = 1'b1;
      st_next.fb_state      = FB_INIT;
      st_next.alias_act     = st_reg.alias_set;  // R04
      st_next.al_code       = 16'h0;
    end else if (fsm_req_i) begin
      if (st_reg.fb_state == FB_INIT && fsm_target_i == FB_PREOP && st_reg.alias_set != st_reg.alias_nv) begin
        st_next.alias_nv = st_reg.alias_set;  // R06
        st_next.nv_write = 1'b1;  // R06
        st_next.al_code  = AL_RESET_NEEDED;  // R07
      end
      unique case (fsm_target_i)
        FB_INIT, FB_PREOP, FB_SAFEOP, FB_OP: st_next.fb_state = fpa_fb_state_t'(fsm_target_i);  // R09
        default: st_next.fb_state = st_reg.fb_state;
      endcase
    end
    for (int i = 0; i < 2; i++) begin
      st_next.low_prio[2*i]   = (st_next.sm_cnt[i] == 8'h1) && st_next.first_slow[i];  // R15
      st_next.low_prio[2*i+1] = (st_next.sm_cnt[i] > 8'h1);  // R13
    end
    st_next.kpd_rdata = is_cfg(kpd_menu_i, kpd_param_i) ? cfg_val(kpd_param_i, st_reg) : kp_rdata;  // R23
    if (ifc_rd_i) begin
      st_next.ifc_rdata = ((ifc_sii_i && ifc_addr_i == SII_ALIAS_WORD) || (!ifc_sii_i && ifc_addr_i == REG_ALIAS))
                        ? st_reg.alias_nv : 16'h0;  // R08
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st_reg           <= '0;
      st_reg.fb_state  <= FB_INIT;  // R09
      st_reg.alias_set <= ALIAS_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rsp_valid_o      = st_reg.rsp_valid;
  assign rsp_abort_o      = st_reg.rsp_abort;
  assign rsp_data_o       = st_reg.rsp_data;
  assign kpd_rdata_o      = st_reg.kpd_rdata;
  assign ifc_rdata_o      = st_reg.ifc_rdata;
  assign state_ind_o      = st_reg.fb_state;  // R10
  assign alias_act_o      = st_reg.alias_act;
  assign alias_nv_o       = st_reg.alias_nv;
  assign nv_write_o       = st_reg.nv_write;
  assign al_code_o        = st_reg.al_code;
  assign save_pulse_o     = st_reg.save_pulse;
  assign save_skip_menu_o = APP_MENU;  // R03
  assign restart_pulse_o  = st_reg.restart_pulse;
  assign pdo_low_prio_o   = st_reg.low_prio;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_restart_wr;
    sdo_req_i && sdo_srv_i == SRV_DOWNLOAD && sdo_index_i == {PARAM_IDX_HI, CFG_MENU}
      && sdo_sub_i == P_RESTART && sdo_data_i == 32'h1 && !st_reg.restart;
  endsequence
  sequence s_restart_run;
    st_reg.restart ##1 (restart_pulse_o && !st_reg.restart && state_ind_o == FB_INIT);
  endsequence
  sequence s_alias_commit;
    fsm_req_i && !st_reg.restart && state_ind_o == FB_INIT && fsm_target_i == FB_PREOP
      && st_reg.alias_set != alias_nv_o;
  endsequence

  a_save_normal: assert property (btn_edge && st_reg.save_cmd == SAVE_CODE  // R01
      |=> save_pulse_o && st_reg.save_cmd == 16'h0)
    else $error("save not triggered by code and reset press");
  a_save_backup: assert property (btn_edge && st_reg.save_cmd == SAVE_CODE_BACKUP  // R02
      |=> save_pulse_o == $past(st_reg.bkp_sync[1]))
    else $error("backup save code handled wrongly");
  a_restart_seq: assert property (s_restart_wr |=> s_restart_run)  // R11
    else $error("restart did not pulse and clear");
  a_restart_no_store: assert property (restart_pulse_o |-> !nv_write_o && !save_pulse_o)  // R12
    else $error("restart wrote storage");
  a_alias_active: assert property (alias_act_o != $past(alias_act_o) |-> restart_pulse_o)  // R04
    else $error("alias took effect without restart");
  a_alias_commit: assert property (s_alias_commit  // R06
      |=> nv_write_o && alias_nv_o == $past(st_reg.alias_set) && al_code_o == AL_RESET_NEEDED)
    else $error("alias not committed on init to preop");
  a_state_onehot: assert property (sdo_req_i && sdo_index_i == {PARAM_IDX_HI, CFG_MENU}  // R10
      && sdo_sub_i == P_STATE
      |=> $onehot(state_ind_o) && (state_ind_o == $past(state_ind_o) || $past(st_reg.restart || fsm_req_i)))
    else $error("run-state not one-hot after write");
  a_map_abort: assert property (sdo_req_i && sdo_srv_i == SRV_DOWNLOAD && sdo_index_i[15:9] == TX_MAP_HI  // R14
      && sdo_sub_i != 8'h0 && is_slow(sdo_data_i) && sdo_index_i == st_reg.sm_first[1] && st_reg.sm_cnt[1] > 8'h1
      |=> rsp_valid_o && rsp_abort_o && rsp_data_o == AB_NOT_MAPPABLE)
    else $error("slow first PDO not aborted");
  a_sub0_read: assert property (sdo_req_i && sdo_srv_i == SRV_UPLOAD && is_par && sdo_sub_i == 8'h0  // R19
      |=> rsp_valid_o && !rsp_abort_o && rsp_data_o == 32'(PARAMS - 1))
    else $error("sub-index 0 did not return highest parameter");
  a_save_alias_only: assert property (sdo_req_i && (sdo_srv_i == SRV_DOWNLOAD || sdo_srv_i == SRV_UPLOAD)  // R20
      && sdo_index_i == {PARAM_IDX_HI, CFG_MENU} && sdo_sub_i == P_SAVE
      |=> rsp_valid_o && rsp_abort_o == ($past(sdo_srv_i) == SRV_DOWNLOAD)
      && rsp_data_o == (rsp_abort_o ? AB_READ_ONLY : 32'(PARAMS - 1)))
    else $error("save command reached outside alias");
endmodule : fpa_access

// ===== dv/fpa_master_model.sv
// Fieldbus master model issuing SDO requests
`timescale 1ns/1ns
module fpa_master_model
  import fpa_pkg::*;
(
  input  wire logic        sys_clk_i,    // System clock
  output logic             sdo_req_o,    // Request strobe
  output logic      [1:0]  sdo_srv_o,    // Service
  output logic      [15:0] sdo_index_o,  // Object index
  output logic      [7:0]  sdo_sub_o,    // Sub-index
  output logic      [31:0] sdo_data_o,   // Download data
  input  wire logic        rsp_valid_i,  // Answer strobe
  input  wire logic        rsp_abort_i,  // Answer is abort
  input  wire logic [31:0] rsp_data_i    // Answer data
);
  initial begin
    {sdo_req_o, sdo_srv_o, sdo_index_o, sdo_sub_o, sdo_data_o} = '0;
  end

  task automatic xfer(input logic [1:0] v, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
                      output logic ab, output logic [31:0] q, output logic ok);
    int n;
    ok = 1'b0;
    @(negedge sys_clk_i);
    sdo_req_o   = 1'b1;
    sdo_srv_o   = v;
    sdo_index_o = i;
    sdo_sub_o   = s;
    sdo_data_o  = d;
    for (n = 0; n < 4 && !ok; n++) begin
      @(negedge sys_clk_i);
      sdo_req_o = 1'b0;
      if (rsp_valid_i === 1'b1) begin
        ok = 1'b1;
        ab = rsp_abort_i;
        q  = rsp_data_i;
      end
    end
    // Released fields carry no stale value
    sdo_index_o = ~i;
    sdo_sub_o   = ~s;
    sdo_data_o  = ~d;
  endtask : xfer
endmodule : fpa_master_model

// ===== dv/fpa_access_test.sv
// Self-checking bench for the fieldbus parameter access block
`timescale 1ns/1ns
module fpa_access_test import fpa_pkg::*; ;
  logic        clk, rst, req, vld, abt, kwe, freq, btn, bak, rd, slave_information_data, nvw, spl, rpl;
  logic [1:0]  srv;
  logic [3:0]  ftg, st, lp;
  logic [7:0]  sub, km, kp, skip;
  logic [15:0] idx, iad, ird, aact, anv, alc;
  logic [31:0] dat, rdat, kd, krd;
  int          n_fail = 0;
  int          n_tests = 0;

  fpa_access u_fpa_access (.sys_clk_i(clk), .sys_rst_i(rst), .sdo_req_i(req), .sdo_srv_i(srv),
    .sdo_index_i(idx), .sdo_sub_i(sub), .sdo_data_i(dat), .rsp_valid_o(vld), .rsp_abort_o(abt),
    .rsp_data_o(rdat), .kpd_we_i(kwe), .kpd_menu_i(km), .kpd_param_i(kp), .kpd_data_i(kd),
    .kpd_rdata_o(krd), .fsm_req_i(freq), .fsm_target_i(ftg), .reset_btn_i(btn), .backup_supply_i(bak),
    .ifc_rd_i(rd), .ifc_sii_i(slave_information_data), .ifc_addr_i(iad), .ifc_rdata_o(ird), .state_ind_o(st),
    .alias_act_o(aact), .alias_nv_o(anv), .nv_write_o(nvw), .al_code_o(alc), .save_pulse_o(spl),
    .save_skip_menu_o(skip), .restart_pulse_o(rpl), .pdo_low_prio_o(lp));
  fpa_master_model u_fpa_master_model (.sys_clk_i(clk), .sdo_req_o(req), .sdo_srv_o(srv),
    .sdo_index_o(idx), .sdo_sub_o(sub), .sdo_data_o(dat), .rsp_valid_i(vld), .rsp_abort_i(abt),
    .rsp_data_i(rdat));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic sd(input logic [1:0] v, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
                    input logic ea, input logic [31:0] eq, input logic cq);
    logic        a;
    logic [31:0] q;
    logic        ok;
    u_fpa_master_model.xfer(v, i, s, d, a, q, ok);
    chk("answer", 32'h1, {31'h0, ok});
    chk("abort flag", {31'h0, ea}, {31'h0, a});
    if (cq) chk("answer data", eq, q);
  endtask : sd

  task automatic rdi(input logic s, input logic [15:0] a, input logic [15:0] e);
    @(negedge clk);
    rd  = 1'b1;
    slave_information_data = s;
    iad = a;
    @(negedge clk);
    rd = 1'b0;
    chk("interface read", {16'h0, e}, {16'h0, ird});
  endtask : rdi

  task automatic fsm_go(input logic [3:0] t, input logic [3:0] e);
    @(negedge clk);
    freq = 1'b1;
    ftg  = t;
    @(negedge clk);
    freq = 1'b0;
    chk("run state", {28'h0, e}, {28'h0, st});
  endtask : fsm_go

  // Button held long enough to pass the two-flop synchroniser
  task automatic press(input logic [31:0] n_exp);
    int c;
    c = 0;
    @(negedge clk);
    btn = 1'b1;
    repeat (8) begin
      @(negedge clk);
      if (spl === 1'b1) c++;
    end
    btn = 1'b0;
    repeat (4) @(negedge clk);
    chk("save pulses", n_exp, c);
  endtask : press

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("[FAIL] run length expected finish seen timeout");
    give_verdict;
  end

  initial begin
    {kwe, km, kp, kd, freq, ftg, btn, bak, rd, slave_information_data, iad} = '0;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk("run state", 32'h1, {28'h0, st});
    chk("alias in use", 32'h0, {16'h0, aact});
    chk("skipped menu", {24'h0, APP_MENU}, {24'h0, skip});
    sd(SRV_DOWNLOAD, 16'h2014, 8'h15, 32'h1234abcd, 1'b0, 32'h0, 1'b0);
    km = 8'h14;
    kp = 8'h15;
    repeat (2) @(negedge clk);
    chk("keypad read", 32'h1234abcd, krd);
    kwe = 1'b1;
    kp  = 8'h16;
    kd  = 32'h00c0ffee;
    @(negedge clk);
    kwe = 1'b0;
    sd(SRV_UPLOAD, 16'h2014, 8'h16, 32'h0, 1'b0, 32'h00c0ffee, 1'b1);
    sd(SRV_UPLOAD, 16'h2014, 8'h00, 32'h0, 1'b0, PARAM_COUNT - 1, 1'b1);
    sd(SRV_NONE, 16'h2014, 8'h15, 32'h0, 1'b1, AB_BAD_CMD, 1'b1);
    sd(SRV_ABORT, 16'h2014, 8'h15, 32'h0, 1'b0, 32'h0, 1'b1);
    sd(SRV_UPLOAD, 16'ha000, 8'h00, 32'h0, 1'b1, AB_NO_OBJECT, 1'b1);
    sd(SRV_UPLOAD, 16'h2014, 8'h33, 32'h0, 1'b1, AB_NO_SUB, 1'b1);
    sd(SRV_DOWNLOAD, 16'h2011, P_ALIAS, 32'h00010000, 1'b1, AB_RANGE, 1'b1);
    sd(SRV_DOWNLOAD, 16'h2011, P_ALIAS, 32'h0000ffff, 1'b0, 32'h0, 1'b0);
    sd(SRV_UPLOAD, 16'h2011, P_ALIAS, 32'h0, 1'b0, 32'h0000ffff, 1'b1);
    chk("alias before restart", 32'h0, {16'h0, aact});
    freq = 1'b1;
    ftg  = FB_PREOP;
    @(negedge clk);
    freq = 1'b0;
    chk("run state", 32'h2, {28'h0, st});
    chk("alias commit", 32'h1, {31'h0, nvw});
    chk("stored alias", 32'hffff, {16'h0, anv});
    chk("status code", {16'h0, AL_RESET_NEEDED}, {16'h0, alc});
    rdi(1'b1, SII_ALIAS_WORD, 16'hffff);
    rdi(1'b0, REG_ALIAS, 16'hffff);
    rdi(1'b0, 16'h0010, 16'h0000);
    fsm_go(FB_SAFEOP, FB_SAFEOP);
    fsm_go(4'h3, FB_SAFEOP);
    fsm_go(FB_OP, FB_OP);
    sd(SRV_DOWNLOAD, 16'h2011, P_RESTART, 32'h1, 1'b0, 32'h0, 1'b0);
    @(negedge clk);
    chk("restart pulse", 32'h1, {31'h0, rpl});
    chk("alias after restart", 32'hffff, {16'h0, aact});
    chk("status after restart", 32'h0, {16'h0, alc});
    chk("run state", 32'h1, {28'h0, st});
    chk("no storage write", 32'h0, {30'h0, nvw, spl});
    sd(SRV_UPLOAD, 16'h2011, P_RESTART, 32'h0, 1'b0, 32'h0, 1'b1);
    sd(SRV_DOWNLOAD, 16'h2011, P_RESTART, 32'h2, 1'b1, AB_RANGE, 1'b1);
    sd(SRV_DOWNLOAD, 16'h2011, P_STATE, 32'h8, 1'b0, 32'h0, 1'b0);
    @(negedge clk);
    chk("forced run state", 32'h1, {28'h0, st});
    sd(SRV_DOWNLOAD, 16'h203d, ALIAS_PARAM, {16'h0, SAVE_CODE}, 1'b0, 32'h0, 1'b0);
    press(32'h1);
    sd(SRV_DOWNLOAD, 16'h2011, P_SAVE, {16'h0, SAVE_CODE}, 1'b1, AB_READ_ONLY, 1'b1);
    sd(SRV_UPLOAD, 16'h2011, P_SAVE, 32'h0, 1'b0, PARAM_COUNT - 1, 1'b1);
    sd(SRV_UPLOAD, 16'h203d, ALIAS_PARAM, 32'h0, 1'b0, 32'h0, 1'b1);
    sd(SRV_DOWNLOAD, 16'h203d, ALIAS_PARAM, {16'h0, SAVE_CODE_BACKUP}, 1'b0, 32'h0, 1'b0);
    press(32'h0);
    bak = 1'b1;
    sd(SRV_DOWNLOAD, 16'h203d, ALIAS_PARAM, {16'h0, SAVE_CODE_BACKUP}, 1'b0, 32'h0, 1'b0);
    press(32'h1);
    sd(SRV_DOWNLOAD, 16'h1c13, 8'h00, 32'h2, 1'b0, 32'h0, 1'b0);
    sd(SRV_DOWNLOAD, 16'h1c13, 8'h01, 32'h1a00, 1'b0, 32'h0, 1'b0);
    sd(SRV_DOWNLOAD, 16'h1a00, 8'h01, {16'h2014, 8'h15, 8'h20}, 1'b1, AB_NOT_MAPPABLE, 1'b1);
    sd(SRV_DOWNLOAD, 16'h1a00, 8'h01, {16'h2012, 8'h16, 8'h10}, 1'b0, 32'h0, 1'b0);
    @(negedge clk);
    chk("second low priority", 32'h8, {28'h0, lp});
    sd(SRV_DOWNLOAD, IDX_SM_ASSIGN, 8'h00, 32'h1, 1'b0, 32'h0, 1'b0);
    sd(SRV_DOWNLOAD, IDX_SM_ASSIGN, 8'h01, 32'h1600, 1'b0, 32'h0, 1'b0);
    sd(SRV_DOWNLOAD, 16'h1600, 8'h01, {16'h2014, 8'h15, 8'h20}, 1'b0, 32'h0, 1'b0);
    @(negedge clk);
    chk("single low priority", 32'h9, {28'h0, lp});
    give_verdict;
  end
endmodule : fpa_access_test
